// ==== design/strap_pll_ratio_pkg.sv ====
// Constants for the strap-sampled PLL ratio and clock range block
package strap_pll_ratio_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_STRAP_STATUS = 8'h00;
	localparam logic [7:0] OFS_RATIO = 8'h04;
	localparam logic [7:0] OFS_REF_FREQ = 8'h08;
	localparam logic [7:0] OFS_LB_CTRL = 8'h0C;
	localparam logic [7:0] OFS_FREQ_STATUS = 8'h10;
	// Strap status field positions
	localparam int POS_PLAT_CODE = 0;
	localparam int POS_CORE_CODE = 8;
	localparam int POS_PLAT_RES = 16;
	localparam int POS_CORE_RES = 17;
	localparam int POS_CFG_ERR = 18;
	localparam int POS_CAPTURED = 19;
	localparam int POS_LOCK = 24;
	// Ratio register field positions
	localparam int POS_PLAT_MULT = 0;
	localparam int POS_CORE_HALVES = 8;
	// Frequency status bit positions
	localparam int POS_PLAT_OK = 0;
	localparam int POS_CORE_OK = 1;
	localparam int POS_MEM_OK = 2;
	localparam int POS_LB_OK = 3;
	localparam int POS_NET_OK = 4;
	localparam int POS_SPEED_OK = 5;
	// Reset values
	localparam logic [15:0] RST_REF_FREQ = 16'h2710;
	localparam logic [4:0] RST_LB_DIV = 5'h08;
	localparam logic [4:0] LB_DIV_MIN = 5'h02;
	// Frequency limits, all in units of 10 kHz
	localparam logic [24:0] PLAT_MIN_F = 25'd33300;
	localparam logic [24:0] PLAT_MAX_F = 25'd53300;
	localparam logic [24:0] MEM_MIN_F = 25'd16600;
	localparam logic [24:0] MEM_MAX_F = 25'd26600;
	localparam logic [24:0] LB_MIN_F = 25'd2200;
	localparam logic [24:0] LB_MAX_F = 25'd13300;
	localparam logic [24:0] CORE_MIN_F = 25'd66600;
	localparam logic [24:0] NET_DIV_F = 25'd40000;
	localparam logic [24:0] CORE_SPEED_F = 25'd80000;
	localparam logic [24:0] FREQ_UNITS_PER_MHZ = 25'd100;
	// Clock and lock timing
	localparam int CLK_MHZ = 10;
	localparam int LOCK_TIME_US = 100;
	localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
	localparam int NUM_PLL = 6;
	localparam int SETTLE_CYCLES = 2;
	// AHB encodings
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	// Capture sequencing
	typedef enum logic [1:0] {CAP_WAIT, CAP_TAKE, CAP_DONE} cap_state_t;
endpackage

// ==== design/strap_pll_ratio_config.sv ====
// Strap capture, ratio decode, derived clocks and range checks with an AHB-Lite slave
// Behaviour
// - Platform clock and system bus clock are one clock, here sys_clk for all logic.
// - Six PLLs are present: platform, core, PCI and the serial-lane PLLs, each with a lock timer.
// - The platform PLL multiplies the reference by the five-bit platform code.
// - The core PLL derives the core clock from the platform clock by the four-bit core code.
// - The platform code is captured at power-up as one display pin then four address pins.
// - Legal platform codes 2-10, 12, 14-18 give a multiplier equal to their value, others are reserved.
// - The core code is captured at power-up from bus control, latch enable, line two, display bit four.
// - Core codes 1000,1010,1100,1110,0000,0010 give 2, 2.5, 3, 3.5, 4, 4.5; others are reserved.
// - The memory clock is half the platform clock and is checked against 166 to 266 MHz.
// - The local bus clock is the platform clock over the divide field, checked against 22 to 133 MHz.
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module strap_pll_ratio_config
	import strap_pll_ratio_pkg::*;
#(
	parameter int CORE_MAX_MHZ = 1333
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Strap pins, sampled at power-up
	input wire logic display_data_pins,
	input wire logic [3:0] local_address_pins,
	input wire logic local_bus_ctl_pin,
	input wire logic address_latch_enable_pin,
	input wire logic general_purpose_line_two,
	input wire logic display_data_bit_four,
	input wire logic core_speed_strap,
	input wire logic network_divider_strap,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Clock and lock outputs
	output logic [4:0] platform_ratio,
	output logic [3:0] core_ratio_halves,
	output logic [NUM_PLL-1:0] pll_locked,
	output logic config_error,
	output logic memory_clock_out,
	output logic local_bus_clock_out
);

	localparam int STRAP_W = 11;
	localparam logic [24:0] CORE_MAX_F = 25'(CORE_MAX_MHZ) * FREQ_UNITS_PER_MHZ;
	localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
	// Transfer size code for one whole word
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// Known register offsets
	function automatic logic reg_hit(input logic [7:0] ofs);
		reg_hit = (ofs == OFS_STRAP_STATUS) || (ofs == OFS_RATIO) || (ofs == OFS_REF_FREQ)
			|| (ofs == OFS_LB_CTRL) || (ofs == OFS_FREQ_STATUS);
	endfunction

	// Registers sit in the lowest 256 bytes; anything above is unmapped
	function automatic logic in_window(input logic [31:0] addr);
		in_window = (addr[31:8] == 24'h000000);
	endfunction

	logic [STRAP_W-1:0] strap_meta;
	logic [STRAP_W-1:0] strap_sync;
	cap_state_t cap_state;
	logic [1:0] settle_cnt;
	logic [4:0] plat_code;
	logic [3:0] core_code;
	logic speed_strap;
	logic net_strap;
	logic captured;
	logic [4:0] next_plat_mult;
	logic [3:0] next_core_halves;
	logic plat_res;
	logic core_res;
	logic [15:0] ref_freq;
	logic [4:0] lb_div_field;
	logic [4:0] lb_div;
	logic [4:0] lb_cnt;
	logic [24:0] plat_f;
	logic [24:0] core_x2_f;
	logic [5:0] freq_ok;
	logic [NUM_PLL-1:0] pll_en;
	logic wr_pend;
	logic [7:0] wr_ofs;
	logic [31:0] read_word;

	// Two-stage synchroniser on every strap pin
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			strap_meta <= '0;
			strap_sync <= '0;
		end else begin
			strap_meta <= {display_data_pins, local_address_pins, local_bus_ctl_pin,
				address_latch_enable_pin, general_purpose_line_two, display_data_bit_four,
				core_speed_strap, network_divider_strap};
			strap_sync <= strap_meta;
		end
	end

	// Capture sequencer, waits out the synchroniser after release
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cap_state <= CAP_WAIT;
			settle_cnt <= '0;
		end else begin
			case (cap_state)
				CAP_WAIT: begin
					// Two edges let the pins reach strap_sync before they are taken
					settle_cnt <= settle_cnt + 2'h1;
					if (settle_cnt == 2'(SETTLE_CYCLES - 1)) begin
						cap_state <= CAP_TAKE;
					end
				end
				CAP_TAKE: cap_state <= CAP_DONE;
				CAP_DONE: cap_state <= CAP_DONE;
				default: cap_state <= CAP_WAIT;
			endcase
		end
	end

	// Straps are taken once; later pin changes are ignored until next reset
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			plat_code <= '0;
			core_code <= '0;
			speed_strap <= 1'b0;
			net_strap <= 1'b0;
			captured <= 1'b0;
		end else if (cap_state == CAP_TAKE) begin
			// display pin is the MSB, then address pins
			plat_code <= strap_sync[10:6];
			// bus control first, display bit four last
			core_code <= strap_sync[5:2];
			speed_strap <= strap_sync[1];
			net_strap <= strap_sync[0];
			captured <= 1'b1;
		end
	end

	// Ratio decode of the captured codes
	always_comb begin
		next_plat_mult = '0;
		plat_res = 1'b0;
		// legal codes map to their own value
		case (plat_code)
			5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A,
			5'h0C, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12: next_plat_mult = plat_code;
			default: plat_res = 1'b1;
		endcase
		next_core_halves = '0;
		core_res = 1'b0;
		// core ratio kept in half steps
		case (core_code)
			4'h8: next_core_halves = 4'h4;
			4'hA: next_core_halves = 4'h5;
			4'hC: next_core_halves = 4'h6;
			4'hE: next_core_halves = 4'h7;
			4'h0: next_core_halves = 4'h8;
			4'h2: next_core_halves = 4'h9;
			default: core_res = 1'b1;
		endcase
	end

	// Decoded ratios and error flag; reserved codes publish zero ratio
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			platform_ratio <= '0;
			core_ratio_halves <= '0;
			config_error <= 1'b0;
		end else begin
			platform_ratio <= captured ? next_plat_mult : 5'h00;
			core_ratio_halves <= captured ? next_core_halves : 4'h0;
			config_error <= captured && (plat_res || core_res);
		end
	end

	// Platform and core PLL enables held off on their reserved codes
	always_comb begin
		pll_en = '0;
		pll_en[0] = captured && !plat_res;
		pll_en[1] = pll_locked[0] && !core_res;
		for (int i = 2; i < NUM_PLL; i++) begin
			pll_en[i] = captured;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_PLL; g++) begin : gen_lock
			logic [LOCK_W-1:0] lock_cnt;
			// Counter parks at the limit, so a lock holds until reset or disable
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					lock_cnt <= '0;
					pll_locked[g] <= 1'b0;
				end else if (!pll_en[g]) begin
					lock_cnt <= '0;
					pll_locked[g] <= 1'b0;
				end else if (lock_cnt != LOCK_W'(LOCK_CYCLES)) begin
					lock_cnt <= lock_cnt + LOCK_W'(1);
				end else begin
					pll_locked[g] <= 1'b1;
				end
			end
		end
	endgenerate

	// memory clock at half the platform rate
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			memory_clock_out <= 1'b0;
		end else begin
			// Free-running, so its phase is fixed by reset release
			memory_clock_out <= !memory_clock_out;
		end
	end

	// Divide field below two would give no clock, so it is raised to two
	assign lb_div = (lb_div_field < LB_DIV_MIN) ? LB_DIV_MIN : lb_div_field;

	// local bus clock divided from platform clock
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lb_cnt <= '0;
			local_bus_clock_out <= 1'b0;
		end else begin
			// A divide whose end the count has reached wraps the counter at once, otherwise it wraps at its new end
			lb_cnt <= (lb_cnt >= lb_div - 5'h01) ? 5'h00 : lb_cnt + 5'h01;
			local_bus_clock_out <= (lb_cnt < (lb_div >> 1));
		end
	end

	// Frequencies from the programmed reference, in 10 kHz units
	assign plat_f = 25'(ref_freq) * 25'(platform_ratio);
	assign core_x2_f = plat_f * 25'(core_ratio_halves);

	// Range and strap consistency checks, informational only
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			freq_ok <= '0;
		end else begin
			freq_ok[POS_PLAT_OK] <= (plat_f >= PLAT_MIN_F) && (plat_f <= PLAT_MAX_F);
			// core window, compared at twice the rate
			freq_ok[POS_CORE_OK] <= (core_x2_f >= (CORE_MIN_F << 1))
				&& (core_x2_f <= (CORE_MAX_F << 1));
			// memory window on half the platform
			freq_ok[POS_MEM_OK] <= ((plat_f >> 1) >= MEM_MIN_F) && ((plat_f >> 1) <= MEM_MAX_F);
			// local bus window on the platform over the divide, limits scaled by lb_div
			freq_ok[POS_LB_OK] <= (plat_f >= LB_MIN_F * 25'(lb_div))
				&& (plat_f <= LB_MAX_F * 25'(lb_div));
			// network divider strap must be low at low platform rate
			freq_ok[POS_NET_OK] <= !(net_strap && (plat_f <= NET_DIV_F));
			// core speed strap must be low at low core rate
			freq_ok[POS_SPEED_OK] <= !(speed_strap && (core_x2_f <= (CORE_SPEED_F << 1)));
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		read_word = '0;
		case (haddr[7:0])
			OFS_STRAP_STATUS: begin
				read_word[POS_PLAT_CODE +: 5] = plat_code;
				read_word[POS_CORE_CODE +: 4] = core_code;
				read_word[POS_PLAT_RES] = captured && plat_res;
				read_word[POS_CORE_RES] = captured && core_res;
				read_word[POS_CFG_ERR] = config_error;
				read_word[POS_CAPTURED] = captured;
				read_word[POS_LOCK +: NUM_PLL] = pll_locked;
			end
			OFS_RATIO: begin
				read_word[POS_PLAT_MULT +: 5] = platform_ratio;
				read_word[POS_CORE_HALVES +: 4] = core_ratio_halves;
			end
			OFS_REF_FREQ: read_word[15:0] = ref_freq;
			OFS_LB_CTRL: read_word[4:0] = lb_div_field;
			OFS_FREQ_STATUS: read_word[5:0] = freq_ok;
			default: read_word = '0;
		endcase
		if (!in_window(haddr)) begin
			read_word = '0;
		end
	end

	// bus slave on the platform clock, no wait states
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY[0];
			hrdata <= '0;
			wr_pend <= 1'b0;
			wr_ofs <= '0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY[0];
			wr_pend <= 1'b0;
			if (hsel && htrans[1] && hready) begin
				// Part-word writes are dropped; reads return the whole word whatever the size
				wr_pend <= hwrite && reg_hit(haddr[7:0]) && in_window(haddr)
					&& (hsize == HSIZE_WORD);
				wr_ofs <= haddr[7:0];
				if (!hwrite) begin
					hrdata <= read_word;
				end
			end
		end
	end

	// Writable registers, written in the data phase
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ref_freq <= RST_REF_FREQ;
			lb_div_field <= RST_LB_DIV;
		end else if (wr_pend) begin
			if (wr_ofs == OFS_REF_FREQ) begin
				ref_freq <= hwdata[15:0];
			end
			if (wr_ofs == OFS_LB_CTRL) begin
				lb_div_field <= hwdata[4:0];
			end
		end
	end

endmodule // strap_pll_ratio_config
`default_nettype wire

// ==== dv/ratio_checker_assertions.sv ====
// Port-level assertions for the strap ratio block
`timescale 1ns/10ps
`default_nettype none
module ratio_checker
	import strap_pll_ratio_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Watched outputs
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [4:0] platform_ratio,
	input wire logic [3:0] core_ratio_halves,
	input wire logic [NUM_PLL-1:0] pll_locked,
	input wire logic config_error,
	input wire logic memory_clock_out
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Zero wait states and OKAY only
	a_bus_ready_okay: assert property (hreadyout && !hresp)
		else $error("bus stalled or answered with error");
	a_plat_mult_legal: assert property (
		platform_ratio != 5'h00 |-> platform_ratio inside {[5'h02:5'h0A], 5'h0C, [5'h0E:5'h12]})
		else $error("platform multiplier outside legal set");
	a_core_ratio_legal: assert property (
		core_ratio_halves inside {4'h0, [4'h4:4'h9]}) else $error("core ratio outside legal set");
	a_error_has_cause: assert property (
		config_error |-> (platform_ratio == 5'h00 || core_ratio_halves == 4'h0))
		else $error("error flag without reserved code");
	a_plat_lock_gated: assert property (
		platform_ratio == 5'h00 |-> !pll_locked[0]) else $error("platform locked without ratio");
	a_core_lock_gated: assert property (
		core_ratio_halves == 4'h0 |-> !pll_locked[1]) else $error("core locked without ratio");
	a_core_after_plat: assert property (
		pll_locked[1] |-> pll_locked[0]) else $error("core locked before platform");
	a_mem_half_rate: assert property (
		$past(rstn) |-> memory_clock_out != $past(memory_clock_out))
		else $error("memory clock missed a toggle");
	a_ratio_held: assert property (
		platform_ratio != 5'h00 |=> $stable(platform_ratio)) else $error("captured ratio moved");
	// Main scenarios reached
	c_core_lock: cover property ($rose(pll_locked[1]));
	c_cfg_error: cover property ($rose(config_error));
	c_top_mult: cover property (platform_ratio == 5'h12);
endmodule // ratio_checker
bind strap_pll_ratio_config ratio_checker u_chk (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.platform_ratio(platform_ratio),
	.core_ratio_halves(core_ratio_halves),
	.pll_locked(pll_locked),
	.config_error(config_error),
	.memory_clock_out(memory_clock_out)
);
`default_nettype wire

// ==== dv/board_straps.sv ====
// Board strap resistor model feeding the ratio straps
`timescale 1ns/10ps
`default_nettype none
module board_straps (
	// Intended ratio codes
	input wire logic [4:0] plat_code,
	input wire logic [3:0] core_code,
	// Intended levels of the speed and network straps
	input wire logic speed_level,
	input wire logic net_level,
	// Strap pins
	output logic display_data_pins,
	output logic [3:0] local_address_pins,
	output logic local_bus_ctl_pin,
	output logic address_latch_enable_pin,
	output logic general_purpose_line_two,
	output logic display_data_bit_four,
	output logic core_speed_strap,
	output logic network_divider_strap
);
	assign display_data_pins = plat_code[4];
	assign local_address_pins = plat_code[3:0];
	assign {local_bus_ctl_pin, address_latch_enable_pin} = core_code[3:2];
	assign {general_purpose_line_two, display_data_bit_four} = core_code[1:0];
	// low in normal runs; raised only to exercise the consistency check
	assign core_speed_strap = speed_level;
	assign network_divider_strap = net_level;
endmodule // board_straps
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the strap ratio block
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import strap_pll_ratio_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [4:0] plat_code = 5'h00;
	logic [3:0] core_code = 4'h0;
	logic spd_lvl = 1'b0;
	logic net_lvl = 1'b0;
	logic dd, bc, ale, gp2, db4, spd, net;
	logic [3:0] la;
	logic hreadyout, hresp, config_error, memory_clock_out, local_bus_clock_out;
	logic [31:0] hrdata;
	logic [4:0] platform_ratio;
	logic [3:0] core_ratio_halves;
	logic [NUM_PLL-1:0] pll_locked;
	int num_errors = 0;
	int n_compared = 0;
	int i;
	logic [4:0] p;
	logic [3:0] c;
	logic [31:0] e, rd;
	logic pr, cr;
	// Platform clock stand-in, 100 ns period
	always #50 sys_clk = ~sys_clk;
	board_straps u_board (.plat_code(plat_code), .core_code(core_code), .speed_level(spd_lvl),
		.net_level(net_lvl),
		.display_data_pins(dd), .local_address_pins(la), .local_bus_ctl_pin(bc),
		.address_latch_enable_pin(ale), .general_purpose_line_two(gp2),
		.display_data_bit_four(db4), .core_speed_strap(spd), .network_divider_strap(net));
	strap_pll_ratio_config u_dut (.sys_clk(sys_clk), .rstn(rstn), .display_data_pins(dd),
		.local_address_pins(la), .local_bus_ctl_pin(bc), .address_latch_enable_pin(ale),
		.general_purpose_line_two(gp2), .display_data_bit_four(db4), .core_speed_strap(spd),
		.network_divider_strap(net), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .platform_ratio(platform_ratio),
		.core_ratio_halves(core_ratio_halves), .pll_locked(pll_locked),
		.config_error(config_error), .memory_clock_out(memory_clock_out),
		.local_bus_clock_out(local_bus_clock_out));
	task automatic close_out();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Single word transfer, each phase held until hready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		rd = hrdata;
		if (n >= 50) begin
			num_errors++;
			close_out();
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		chk(rd, x);
	endtask
	// Ratio codes change only while reset is low; speed and network levels are set with reset high
	task automatic do_reset(input logic [4:0] pc, input logic [3:0] cc);
		rstn <= 1'b0;
		plat_code <= pc;
		core_code <= cc;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic wait_lock(input logic [NUM_PLL-1:0] m);
		int n;
		for (n = 0; n < 3000 && (pll_locked & m) !== m; n++) begin
			@(posedge sys_clk);
		end
		if (n >= 3000) begin
			num_errors++;
			close_out();
		end
	endtask
	// Last full period seen, so a divide change mid-count is skipped
	task automatic lb_period(input logic [31:0] x);
		int k, r1, per;
		logic o;
		r1 = -1;
		per = 0;
		o = 1'b1;
		for (k = 0; k < 60; k++) begin
			@(posedge sys_clk);
			if (local_bus_clock_out === 1'b1 && o === 1'b0) begin
				if (r1 >= 0) per = k - r1;
				r1 = k;
			end
			o = local_bus_clock_out;
		end
		chk(per, x);
	endtask
	function automatic logic [4:0] mult_of(input logic [4:0] v);
		return (v inside {[5'h02:5'h0A], 5'h0C, [5'h0E:5'h12]}) ? v : 5'h00;
	endfunction
	function automatic logic [3:0] halves_of(input logic [3:0] v);
		return v[0] ? 4'h0 : v[3] ? 4'h4 + {2'h0, v[2:1]} : v[2] ? 4'h0 : 4'h8 + {3'h0, v[1]};
	endfunction
	initial begin
		// Every platform and core code; one reset per platform code, two per core code
		for (i = 0; i < 32; i++) begin
			p = i[4:0];
			c = i[3:0];
			do_reset(p, c);
			pr = mult_of(p) == 5'h00;
			cr = halves_of(c) == 4'h0;
			e = {12'h0, 1'b1, pr | cr, cr, pr, 4'h0, c, 3'h0, p};
			rd_chk(OFS_STRAP_STATUS, e); // capture
			rd_chk(OFS_RATIO, {20'h0, halves_of(c), 3'h0, mult_of(p)}); // decode
			chk({27'h0, platform_ratio}, {27'h0, mult_of(p)}); // port
			chk({28'h0, core_ratio_halves}, {28'h0, halves_of(c)}); // port
			chk({31'h0, config_error}, {31'h0, pr | cr}); // flag
		end
		// 100 MHz reference, 400 MHz platform, 800 MHz core
		do_reset(5'h04, 4'h8);
		rd_chk(OFS_REF_FREQ, {16'h0, RST_REF_FREQ});
		rd_chk(OFS_LB_CTRL, {27'h0, RST_LB_DIV});
		rd_chk(OFS_FREQ_STATUS, 32'h0000_003F); // ranges
		lb_period(32'h8); // divide
		xfer(1'b1, OFS_RATIO, 32'hFFFF_FFFF);
		rd_chk(OFS_RATIO, 32'h0000_0404); // read-only
		rd_chk(8'h14, 32'h0);
		xfer(1'b1, OFS_LB_CTRL, 32'h5);
		rd_chk(OFS_LB_CTRL, 32'h5); // divide field
		hsize <= 3'h0;
		xfer(1'b1, OFS_LB_CTRL, 32'h3);
		hsize <= 3'h2;
		rd_chk(OFS_LB_CTRL, 32'h5); // byte write dropped
		lb_period(32'h5); // odd divide
		xfer(1'b1, OFS_LB_CTRL, 32'h2);
		repeat (3) @(posedge sys_clk);
		rd_chk(OFS_FREQ_STATUS, 32'h0000_0037); // over 133
		xfer(1'b1, OFS_REF_FREQ, 32'h1F40);
		repeat (3) @(posedge sys_clk);
		rd_chk(OFS_FREQ_STATUS, 32'h0000_0030); // below minimum
		wait_lock(6'h3F);
		chk({26'h0, pll_locked}, 32'h3F); // all locked
		// Reserved platform, then reserved core
		do_reset(5'h0B, 4'h8);
		wait_lock(6'h3C);
		repeat (1100) @(posedge sys_clk);
		chk({26'h0, pll_locked}, 32'h3C); // platform held
		do_reset(5'h04, 4'h4);
		wait_lock(6'h3D);
		repeat (1100) @(posedge sys_clk);
		chk({26'h0, pll_locked}, 32'h3D); // core held
		// Speed and network straps high: flagged at 400/800 MHz, allowed at 500/1000 MHz
		spd_lvl <= 1'b1;
		net_lvl <= 1'b1;
		do_reset(5'h04, 4'h8);
		rd_chk(OFS_FREQ_STATUS, 32'h0000_000F); // straps flagged
		do_reset(5'h05, 4'h8);
		rd_chk(OFS_FREQ_STATUS, 32'h0000_003F); // straps allowed
		close_out();
	end
endmodule // tb_top
`default_nettype wire
